// ### hw/adcr_conv_if.sv
// Carrier between the register side and the conversion engine.
`timescale 1ns/1ps
interface adcr_conv_if;
    logic                     enable;
    logic [1:0]               clk_sel;
    logic                     done;
    adcr_pkg::adcr_result_type result;

    modport ctrl   (output enable, output clk_sel, input done, input result);
    modport engine (input enable, input clk_sel, output done, output result);
endinterface : adcr_conv_if

// ### hw/adcr_map.svh
// Register offsets, field positions, reset values and timing counts of the converter block.
`ifndef ADCR_MAP_SVH
`define ADCR_MAP_SVH

// Register indices as printed; the byte address is four times the index.
`define ADCR_IDX_RESULT_LOW   10'h06f
`define ADCR_IDX_RESULT_HIGH  10'h070
`define ADCR_IDX_CONTROL      10'h071
`define ADCR_ADDR_RESULT_LOW  ({`ADCR_IDX_RESULT_LOW, 2'h0})
`define ADCR_ADDR_RESULT_HIGH ({`ADCR_IDX_RESULT_HIGH, 2'h0})
`define ADCR_ADDR_CONTROL     ({`ADCR_IDX_CONTROL, 2'h0})
`define ADCR_ADDR_IRQ_STATUS  12'h000
`define ADCR_ADDR_IRQ_CLEAR   12'h004
`define ADCR_ADDR_IRQ_ENABLE  12'h008

// Control/status field positions.
`define ADCR_CSR_DONE_BIT     7
`define ADCR_CSR_SPEED_BIT    6
`define ADCR_CSR_ENABLE_BIT   5
`define ADCR_CSR_SLOW_BIT     4
`define ADCR_CSR_CHAN_MSB     2
`define ADCR_CSR_CHAN_LSB     0

// Interrupt status layout.
`define ADCR_IRQ_BITS         2
`define ADCR_IRQ_DONE_BIT     0
`define ADCR_IRQ_HELD_BIT     1

// Reset values.
`define ADCR_CSR_RESET        8'h00
`define ADCR_RESULT_RESET     10'h000
`define ADCR_IRQ_RESET        2'h0

// Converter clock: divider terminal counts (divisor minus one).
`define ADCR_DIV_LAST_1       2'h0
`define ADCR_DIV_LAST_2       2'h1
`define ADCR_DIV_LAST_4       2'h3
`define ADCR_SAR_FIRST_BIT    10'h200

// Timing figures: core clock rate and the fastest legal undivided setting.
`define ADCR_CORE_CLK_HZ      25000000
`define ADCR_FAST_MAX_HZ      4000000

// AXI responses.
`define ADCR_RESP_OKAY        2'h0
`define ADCR_RESP_SLVERR      2'h2

`endif

// ### hw/adcr_pkg.sv
// Types shared by the converter control block and its conversion engine.
package adcr_pkg;

    typedef logic [9:0] adcr_result_type;

    typedef enum logic [1:0]
    {
        SAR_IDLE,
        SAR_SAMPLE,
        SAR_CONVERT
    } adcr_sar_state_type;

endpackage : adcr_pkg

// ### hw/adcr_sar.sv
// Converter clock divider and successive-approximation sequencer.
`timescale 1ns/1ps
`include "adcr_map.svh"
module adcr_sar
(
    input  wire logic   core_clk,
    input  wire logic   resetn,
    input  wire logic   ce,
    adcr_conv_if.engine conv,
    input  wire logic   cmp_hi,
    output logic [9:0]  sar_trial,
    output logic        sar_sample
);
    logic [1:0]                     div_cnt_q;
    logic [1:0]                     div_last;
    logic                           tick;
    adcr_pkg::adcr_sar_state_type   state_q;
    adcr_pkg::adcr_result_type      acc_q;
    adcr_pkg::adcr_result_type      mask_q;
    adcr_pkg::adcr_result_type      acc_d;
    logic                           done_q;
    adcr_pkg::adcr_result_type      result_q;

    // Index is {slow, speed}.
    always_comb
    begin
        case (conv.clk_sel)
            2'h1:    div_last = `ADCR_DIV_LAST_1;
            2'h3:    div_last = `ADCR_DIV_LAST_2;
            2'h0:    div_last = `ADCR_DIV_LAST_2;
            default: div_last = `ADCR_DIV_LAST_4;
        endcase
    end

    assign tick  = conv.enable && (div_cnt_q == div_last);
    assign acc_d = cmp_hi ? sar_trial : acc_q;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            div_cnt_q <= 2'h0;
        else if (ce)
            div_cnt_q <= (!conv.enable || tick) ? 2'h0 : div_cnt_q + 2'h1;
    end

    // Disabling drops the sequence at once; a partial result is never published.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q   <= adcr_pkg::SAR_IDLE;
            acc_q     <= `ADCR_RESULT_RESET;
            mask_q    <= `ADCR_RESULT_RESET;
            sar_trial <= `ADCR_RESULT_RESET;
        end
        else if (ce)
        begin
            if (!conv.enable)
                state_q <= adcr_pkg::SAR_IDLE;
            else
            begin
                case (state_q)
                    adcr_pkg::SAR_IDLE:
                        state_q <= adcr_pkg::SAR_SAMPLE;
                    adcr_pkg::SAR_SAMPLE:
                        if (tick)
                        begin
                            state_q   <= adcr_pkg::SAR_CONVERT;
                            acc_q     <= `ADCR_RESULT_RESET;
                            mask_q    <= `ADCR_SAR_FIRST_BIT;
                            sar_trial <= `ADCR_SAR_FIRST_BIT;
                        end
                    adcr_pkg::SAR_CONVERT:
                        if (tick)
                        begin
                            acc_q     <= acc_d;
                            mask_q    <= mask_q >> 1;
                            sar_trial <= acc_d | (mask_q >> 1);
                            if (mask_q[0])
                                state_q <= adcr_pkg::SAR_SAMPLE;
                        end
                    default:
                        state_q <= adcr_pkg::SAR_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done_q   <= 1'b0;
            result_q <= `ADCR_RESULT_RESET;
        end
        else if (ce)
        begin
            done_q <= conv.enable && tick && (state_q == adcr_pkg::SAR_CONVERT) && mask_q[0];
            if (conv.enable && tick && (state_q == adcr_pkg::SAR_CONVERT) && mask_q[0])
                result_q <= acc_d;
        end
    end

    assign conv.done   = done_q;
    assign conv.result = result_q;
    assign sar_sample  = (state_q == adcr_pkg::SAR_SAMPLE);

endmodule : adcr_sar

// ### hw/adcr_top.sv
// Converter control/status and result registers behind an AXI4-Lite slave.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "adcr_map.svh"

module adcr_top
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    output logic             converter_enable,
    output logic [2:0]       input_channel_sel,
    output logic [9:0]       sar_trial,
    output logic             sar_sample,
    input  wire logic        cmp_hi
);

    // Control/status fields.
    logic                      speed_q;
    logic                      slow_q;
    logic                      enable_q;
    logic [2:0]                chan_q;
    logic                      done_flag_q;

    // Result holding registers and the split-read lock.
    logic [1:0]                result_low_q;
    logic [7:0]                result_high_q;
    logic                      lock_q;

    // Interrupt registers.
    logic [`ADCR_IRQ_BITS-1:0] irq_status_q;
    logic [`ADCR_IRQ_BITS-1:0] irq_enable_q;
    logic [`ADCR_IRQ_BITS-1:0] irq_event;

    // AXI write side.
    logic                      aw_have_q;
    logic [11:0]               awaddr_q;
    logic                      w_have_q;
    logic [31:0]               wdata_q;
    logic                      wlane0_q;
    logic                      bvalid_q;
    logic [1:0]                bresp_q;
    logic                      wr_go;
    logic                      wr_hit;
    logic                      wr_csr;
    logic                      wr_irq_clear;
    logic                      wr_irq_enable;

    // AXI read side.
    logic                      rvalid_q;
    logic [31:0]               rdata_q;
    logic [1:0]                rresp_q;
    logic                      rd_go;
    logic                      rd_hit;
    logic [31:0]               rd_word;
    logic                      rd_low;
    logic                      rd_high;

    // Converter side.
    logic [7:0]                csr_view;

    // Reset images held as constants so that single fields can be picked out.
    localparam logic [7:0]     CSR_RST = `ADCR_CSR_RESET;
    localparam logic [9:0]     RES_RST = `ADCR_RESULT_RESET;

    adcr_conv_if conv ();

    adcr_sar u_sar
    (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .ce         (ce),
        .conv       (conv.engine),
        .cmp_hi     (cmp_hi),
        .sar_trial  (sar_trial),
        .sar_sample (sar_sample)
    );

    assign conv.enable  = enable_q;
    assign conv.clk_sel = {slow_q, speed_q};

    // Address decode.
    function automatic logic addr_mapped(input logic [11:0] addr);
        case (addr)
            `ADCR_ADDR_RESULT_LOW,
            `ADCR_ADDR_RESULT_HIGH,
            `ADCR_ADDR_CONTROL,
            `ADCR_ADDR_IRQ_STATUS,
            `ADCR_ADDR_IRQ_CLEAR,
            `ADCR_ADDR_IRQ_ENABLE: addr_mapped = 1'b1;
            default:               addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // Bit 3 has no storage and always reads zero.
    assign csr_view = {done_flag_q, speed_q, enable_q, slow_q, 1'b0, chan_q};

    always_comb
    begin
        case (s_axi_araddr)
            `ADCR_ADDR_RESULT_LOW:  rd_word = {30'h00000000, result_low_q};
            `ADCR_ADDR_RESULT_HIGH: rd_word = {24'h000000, result_high_q};
            `ADCR_ADDR_CONTROL:     rd_word = {24'h000000, csr_view};
            `ADCR_ADDR_IRQ_STATUS:  rd_word = {30'h00000000, irq_status_q};
            `ADCR_ADDR_IRQ_ENABLE:  rd_word = {30'h00000000, irq_enable_q};
            default:                rd_word = 32'h00000000;
        endcase
    end

    // Write channel: address and data are taken in either order.
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign wr_go         = aw_have_q && w_have_q && !bvalid_q;
    assign wr_hit        = addr_mapped(awaddr_q);
    assign wr_csr        = wr_go && wlane0_q && (awaddr_q == `ADCR_ADDR_CONTROL);
    assign wr_irq_clear  = wr_go && wlane0_q && (awaddr_q == `ADCR_ADDR_IRQ_CLEAR);
    assign wr_irq_enable = wr_go && wlane0_q && (awaddr_q == `ADCR_ADDR_IRQ_ENABLE);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aw_have_q <= 1'b0;
            awaddr_q  <= 12'h000;
        end
        else if (ce)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            w_have_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            wlane0_q <= 1'b0;
        end
        else if (ce)
        begin
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wlane0_q <= s_axi_wstrb[0];
            end
            else if (wr_go)
                w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `ADCR_RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `ADCR_RESP_OKAY : `ADCR_RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // Read channel: one read in flight, answered on the next edge.
    assign s_axi_arready = !rvalid_q;
    assign rd_go         = s_axi_arvalid && s_axi_arready;
    assign rd_hit        = addr_mapped(s_axi_araddr);
    assign rd_low        = rd_go && (s_axi_araddr == `ADCR_ADDR_RESULT_LOW);
    assign rd_high       = rd_go && (s_axi_araddr == `ADCR_ADDR_RESULT_HIGH);

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `ADCR_RESP_OKAY;
        end
        else if (ce)
        begin
            if (rd_go)
            begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_hit ? `ADCR_RESP_OKAY : `ADCR_RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // Software-owned control fields; the done flag is not written here.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            speed_q  <= CSR_RST[`ADCR_CSR_SPEED_BIT];
            slow_q   <= CSR_RST[`ADCR_CSR_SLOW_BIT];
            enable_q <= CSR_RST[`ADCR_CSR_ENABLE_BIT];
            chan_q   <= CSR_RST[`ADCR_CSR_CHAN_MSB:`ADCR_CSR_CHAN_LSB];
        end
        else if (ce && wr_csr)
        begin
            speed_q  <= wdata_q[`ADCR_CSR_SPEED_BIT];
            slow_q   <= wdata_q[`ADCR_CSR_SLOW_BIT];
            enable_q <= wdata_q[`ADCR_CSR_ENABLE_BIT];
            chan_q   <= wdata_q[`ADCR_CSR_CHAN_MSB:`ADCR_CSR_CHAN_LSB];
        end
    end

    // Codes six and seven are passed to the input mux unchanged; the mux
    // selects nothing valid for them, so their results are meaningless.
    assign input_channel_sel = chan_q;
    assign converter_enable  = enable_q;

    // A new result wins over a clear that lands in the same cycle.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            done_flag_q <= CSR_RST[`ADCR_CSR_DONE_BIT];
        else if (ce)
        begin
            if (conv.done)
                done_flag_q <= 1'b1;
            else if (rd_high || wr_csr)
                done_flag_q <= 1'b0;
        end
    end

    // Lock taken by a low read and released by a high read.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            lock_q <= 1'b0;
        else if (ce)
        begin
            if (rd_low)
                lock_q <= 1'b1;
            else if (rd_high)
                lock_q <= 1'b0;
        end
    end

    // While locked the high byte keeps the value that pairs with the low
    // read already done; the fresh high bits of that conversion are lost.
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result_low_q  <= RES_RST[1:0];
            result_high_q <= RES_RST[9:2];
        end
        else if (ce && conv.done)
        begin
            result_low_q <= conv.result[1:0];
            if (!lock_q)
                result_high_q <= conv.result[9:2];
        end
    end

    // Interrupt events: every conversion end, and a result whose high part was held back.
    always_comb
    begin
        irq_event                      = '0;
        irq_event[`ADCR_IRQ_DONE_BIT]  = conv.done;
        irq_event[`ADCR_IRQ_HELD_BIT]  = conv.done && lock_q;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irq_status_q <= `ADCR_IRQ_RESET;
        else if (ce)
        begin
            if (wr_irq_clear)
                irq_status_q <= (irq_status_q & ~wdata_q[`ADCR_IRQ_BITS-1:0]) | irq_event;
            else
                irq_status_q <= irq_status_q | irq_event;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            irq_enable_q <= `ADCR_IRQ_RESET;
        else if (ce && wr_irq_enable)
            irq_enable_q <= wdata_q[`ADCR_IRQ_BITS-1:0];
    end

    assign irq = |(irq_status_q & irq_enable_q);

endmodule : adcr_top

// ### verification/adcr_top_assertions.sv
// Port-level checker for the converter register block.
`timescale 1ns/1ps
module adcr_top_assertions
(
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        ce,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        irq,
    input wire logic        converter_enable,
    input wire logic [2:0]  input_channel_sel,
    input wire logic        sar_sample
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    a_reset_clear: assert property ($rose(resetn) |-> !converter_enable && !irq
        && input_channel_sel == 3'h0 && !sar_sample) else $error("state not clear after reset");
    a_read_one: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_write_two: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && !s_axi_bvalid && ce) ##1 ce |=> s_axi_bvalid) else $error("write late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_ctrl_by_write: assert property (!$stable({converter_enable, input_channel_sel})
        |-> $rose(s_axi_bvalid)) else $error("control output moved without a write");
    a_sample_when_on: assert property (sar_sample && $past(ce) |-> $past(converter_enable))
        else $error("sampling while converter off");
    a_off_is_idle: assert property (!converter_enable && ce |=> !sar_sample)
        else $error("conversion goes on after disable");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(irq));
    c_sample: cover property ($rose(sar_sample));
endmodule : adcr_top_assertions

// ### verification/tb_adcr_top.sv
// Self-checking bench for the converter register block.
`timescale 1ns/1ps
`include "adcr_map.svh"
module tb_adcr_top;
    localparam logic [11:0] A_LO = `ADCR_ADDR_RESULT_LOW;
    localparam logic [11:0] A_HI = `ADCR_ADDR_RESULT_HIGH;
    localparam logic [11:0] A_CSR = `ADCR_ADDR_CONTROL;
    localparam logic [11:0] A_IST = `ADCR_ADDR_IRQ_STATUS;
    localparam logic [11:0] A_ICL = `ADCR_ADDR_IRQ_CLEAR;
    localparam logic [11:0] A_IEN = `ADCR_ADDR_IRQ_ENABLE;
    logic        core_clk, resetn, ce;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot, input_channel_sel;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irq, converter_enable, sar_sample;
    logic [9:0]  sar_trial, target;
    wire         cmp_hi;
    int          err_total, checked, cyc, ce_gap, ce_cnt;

    // Stands in for the analog input: a trial code at or below the level keeps its bit.
    assign cmp_hi = (target >= sar_trial);

    adcr_top DUT (.*);

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Clock enable is high one edge in ce_gap + 1, which slows the core down.
    always @(posedge core_clk)
    begin
        ce     <= (ce_cnt >= ce_gap);
        ce_cnt <= (ce_cnt >= ce_gap) ? 0 : ce_cnt + 1;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // Ready is raised only after the request is taken, so back-to-back calls never
    // assign the same signal twice in one time step.
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge core_clk);
            aw_ok = aw_ok | (s_axi_awvalid & s_axi_awready & ce);
            w_ok = w_ok | (s_axi_wvalid & s_axi_wready & ce);
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end
        s_axi_bready <= 1'b1;
        do
            @(posedge core_clk);
        while (!(s_axi_bvalid === 1'b1 && ce === 1'b1));
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
            @(posedge core_clk);
        while (!(s_axi_arready === 1'b1 && ce === 1'b1));
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do
            @(posedge core_clk);
        while (!(s_axi_rvalid === 1'b1 && ce === 1'b1));
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        axi_rd(a, d);
        chk(what, d, exp);
    endtask : rd_chk

    task automatic wait_done();
        logic [31:0] d;
        d = 32'h0;
        while (d[7] !== 1'b1)
            axi_rd(A_CSR, d);
    endtask : wait_done

    task automatic t_reset_values();
        rd_chk("low at reset", A_LO, 32'h0);
        rd_chk("high at reset", A_HI, 32'h0);
        rd_chk("control at reset", A_CSR, 32'h0);
        rd_chk("irq status at reset", A_IST, 32'h0);
    endtask : t_reset_values

    task automatic t_control_bits();
        for (int c = 0; c < 8; c++)
        begin
            axi_wr(A_CSR, 32'h88 | c);
            rd_chk("control readback", A_CSR, c);
            chk("channel output", {29'h0, input_channel_sel}, c);
        end
        axi_wr(A_CSR, 32'hffffffdf);
        chk("write resp", {30'h0, last_resp}, 32'h0);
        s_axi_wstrb <= 4'he;
        axi_wr(A_CSR, 32'h0);
        s_axi_wstrb <= 4'hf;
        rd_chk("control rw bits", A_CSR, 32'h57);
        rd_chk("unmapped read", 12'h100, 32'h0);
        chk("unmapped resp", {30'h0, last_resp}, 32'h2);
        axi_wr(12'h100, 32'h0);
        chk("unmapped write resp", {30'h0, last_resp}, 32'h2);
    endtask : t_control_bits

    task automatic t_clock_div();
        logic [7:0] csr [4];
        int         div [4];
        time        t0;
        csr = '{8'h65, 8'h75, 8'h25, 8'h35};
        div = '{1, 2, 2, 4};
        for (int i = 0; i < 4; i++)
        begin
            ce_gap = (div[i] == 1) ? `ADCR_CORE_CLK_HZ / `ADCR_FAST_MAX_HZ : 0;
            axi_wr(A_CSR, {24'h0, csr[i] & 8'hdf});
            axi_wr(A_CSR, {24'h0, csr[i]});
            chk("enable output", {31'h0, converter_enable}, 32'h1);
            repeat (2) @(posedge sar_sample);
            t0 = $time;
            @(posedge sar_sample);
            chk("conversion period", ($time - t0) / 40, 11 * div[i] * (ce_gap + 1));
            axi_wr(A_CSR, 32'h0);
        end
    endtask : t_clock_div

    // The slowest clock leaves room for several bus cycles between two conversion ends.
    task automatic t_results();
        target <= 10'h2a5;
        axi_wr(A_CSR, 32'h15);
        axi_wr(A_CSR, 32'h35);
        wait_done();
        rd_chk("result low", A_LO, 32'h1);
        rd_chk("result high", A_HI, 32'ha9);
        rd_chk("done cleared by high read", A_CSR, 32'h35);
        target <= 10'h15a;
        wait_done();
        axi_wr(A_CSR, 32'h35);
        rd_chk("done cleared by write", A_CSR, 32'h35);
        wait_done();
        rd_chk("second low", A_LO, 32'h2);
        target <= 10'h3ff;
        repeat (150) @(posedge core_clk);
        rd_chk("low keeps updating", A_LO, 32'h3);
        rd_chk("frozen high", A_HI, 32'h56);
        wait_done();
        rd_chk("high after unlock", A_HI, 32'hff);
    endtask : t_results

    task automatic t_irq();
        axi_wr(A_ICL, 32'h3);
        axi_wr(A_IEN, 32'h1);
        rd_chk("irq enable", A_IEN, 32'h1);
        while (irq !== 1'b1)
            @(posedge core_clk);
        axi_wr(A_CSR, 32'h0);
        rd_chk("irq status", A_IST, 32'h1);
        axi_wr(A_IEN, 32'h0);
        chk("irq masked", {31'h0, irq}, 32'h0);
        axi_wr(A_IEN, 32'h1);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        axi_wr(A_ICL, 32'h1);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        rd_chk("clear reads zero", A_ICL, 32'h0);
        repeat (200) @(posedge core_clk);
        rd_chk("no done when off", A_CSR, 32'h0);
        rd_chk("no event when off", A_IST, 32'h0);
    endtask : t_irq

    initial
    begin
        resetn = 1'b0;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_awprot = 3'h0;
        s_axi_arprot = 3'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        target = 10'h0;
        err_total = 0;
        checked = 0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset_values();
        t_control_bits();
        t_clock_div();
        t_results();
        t_irq();
        test_done();
    end

    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            test_done();
        end
    end
endmodule : tb_adcr_top

bind adcr_top adcr_top_assertions u_chk (.*);
